/* File: logic/breaker_failure_cfg.svh */
// constants of the breaker failure timer: timing, offsets, fields, reset values
`ifndef BREAKER_FAILURE_CFG_SVH
`define BREAKER_FAILURE_CFG_SVH
`define CLK_MHZ 100
`define PROG_CYCLE_US 5000
`define MS_US 1000
`define DELAY_STEP_MS 5
`define CBF_DELAY_MS 200
`define RETRIP_DELAY_MS 100
`define LOG_DEPTH 12
`define N_EV 8
`define N_CNT 4
`define A_CTRL 8'h00
`define A_CBF_DLY 8'h04
`define A_RET_DLY 8'h08
`define A_PH_THR 8'h0C
`define A_RES_THR 8'h10
`define A_EV_MASK 8'h14
`define A_STATUS 8'h18
`define A_CNT_CLR 8'h1C
`define A_CNT0 8'h20
`define CNT_STRIDE 8'h04
`define A_LOG_SEL 8'h30
`define A_LOG_TIME 8'h34
`define A_LOG_INFO 8'h38
`define A_LOG_CUR 8'h3C
`define A_LOG_REM 8'h40
`define A_TIME 8'h44
`define CTRL_RST 32'h0000_0004
`define CTRL_MASK 32'h0000_03FF
`define F_MODE 0
`define F_RET_EN 2
`define F_CUR_SUP 3
`define F_DO_SUP 4
`define F_RES_SEL 5
`define F_GROUP 7
`define THR_RST 16'h0100
`define EV_MASK_RST 16'hFFFF
`define F_ST_STATE 0
`define F_ST_CBF 3
`define F_ST_RET 4
`define F_ST_FILL 8
`define F_ST_EV 16
`define EV_START 0
`define EV_RETRIP 1
`define EV_CBF 2
`define EV_BLOCK 3
`define EV_DO 4
`define EV_SIGNAL 5
`define EV_PHASE 6
`define EV_RES 7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: logic/breaker_failure_pkg.sv */
// types shared by the breaker failure timer
package breaker_failure_pkg;
`include "breaker_failure_cfg.svh"
typedef logic [`N_EV-1:0] ev_vec_t;
typedef enum logic [1:0] {CRIT_CUR = 2'h0, CRIT_AND = 2'h1, CRIT_OR = 2'h2, CRIT_DI = 2'h3} crit_t;
typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_RUN = 3'h2, ST_BLK = 3'h4} bf_state_t;
endpackage

/* File: logic/breaker_failure_timer_logic.sv */
// breaker failure supervision timer with events, counters, record log, axi4-lite
//
// Contract
// - current mode starts delay on phase or residual overcurrent, trip ignored.
// - current mode asserts failure output when current persists for the delay.
// - current mode clears delay counter at once when currents drop.
// - and mode holds counter after current pick-up until trip output drives.
// - and mode asserts output only with current and trip signal both active.
// - and mode clears counter when current drops or trip signal resets.
// - or mode starts counting on current or trip, trip watched regardless.
// - or mode asserts output if either condition lasts the whole delay.
// - or mode clears counter only when current low and trip reset.
// - input mode starts solely from digital input, optional current and trip checks.
// - input mode counts from input activation, commands output at set delay.
// - on and off events for start, retrip, failure, block, monitor, input, currents.
// - per-event mask chooses output of on, off or both event pulses; log ignores it.
// - every recorded event carries a time stamp.
// - resettable counts of retrip, failure, start and blocked occurrences.
// - log keeps the latest twelve time-stamped operation records.
// - log records only on events, capturing present process data.
// - record holds time, event, max phase, residual, remaining times, group.
// - blocking sampled each cycle; blocks at pick-up, resets an active start.
// - delay set in 5 ms steps, default 200 ms, from start condition.
`include "breaker_failure_cfg.svh"
module breaker_failure_timer_logic #(
	parameter int W = 16,
	parameter int CW = 16,
	parameter int PROG_CYCLES = `PROG_CYCLE_US * `CLK_MHZ,
	parameter int MS_CYCLES = `MS_US * `CLK_MHZ
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [W-1:0] phase_current_a,
	input wire logic [W-1:0] phase_current_b,
	input wire logic [W-1:0] phase_current_c,
	input wire logic [W-1:0] residual_input_one,
	input wire logic [W-1:0] residual_input_two,
	input wire logic [W-1:0] residual_calculated,
	input wire logic trip_monitor_pin,
	input wire logic start_input_pin,
	input wire logic block_pin,
	output logic breaker_failure_output,
	output logic retrip_output,
	output logic start_output,
	output logic blocked_output,
	output breaker_failure_pkg::ev_vec_t breaker_failure_event_block_on,
	output breaker_failure_pkg::ev_vec_t breaker_failure_event_block_off,
	output logic [31:0] event_stamp
);
	import breaker_failure_pkg::*;

	localparam int PW = $clog2(PROG_CYCLES + 1);
	localparam int MW = $clog2(MS_CYCLES + 1);
	localparam logic [3:0] LD = 4'(`LOG_DEPTH);

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
		begin
			if (s[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		end
		return r;
	endfunction

	// pins cross in through two flops; only the second stage is read
	logic [2:0] sy1_q, sy2_q;
	logic trip, di, blk;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sy1_q <= 3'h0;
			sy2_q <= 3'h0;
		end
		else
		begin
			sy1_q <= {block_pin, start_input_pin, trip_monitor_pin};
			sy2_q <= sy1_q;
		end
	end
	assign trip = sy2_q[0];
	assign di = sy2_q[1];
	assign blk = sy2_q[2];

	// program cycle tick and millisecond time base
	logic [PW-1:0] pc_q, pc_d;
	logic [MW-1:0] ms_q, ms_d;
	logic [31:0] time_q, time_d;
	logic tick_q, tick_d;
	always_comb
	begin
		pc_d = pc_q + 1'b1;
		tick_d = 1'b0;
		if (pc_q == PW'(PROG_CYCLES - 1))
		begin
			pc_d = '0;
			tick_d = 1'b1;
		end
		ms_d = ms_q + 1'b1;
		time_d = time_q;
		if (ms_q == MW'(MS_CYCLES - 1))
		begin
			ms_d = '0;
			time_d = time_q + 32'h1;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pc_q <= '0;
			ms_q <= '0;
			time_q <= 32'h0;
			tick_q <= 1'b0;
		end
		else
		begin
			pc_q <= pc_d;
			ms_q <= ms_d;
			time_q <= time_d;
			tick_q <= tick_d;
		end
	end

	// software settings
	logic [31:0] ctrl_q, ctrl_d;
	logic [W-1:0] cbf_dly_q, cbf_dly_d, ret_dly_q, ret_dly_d;
	logic [W-1:0] ph_thr_q, ph_thr_d, res_thr_q, res_thr_d;
	logic [15:0] mask_q, mask_d;
	logic [3:0] clr_q, clr_d, sel_q, sel_d;
	crit_t mode;
	assign mode = crit_t'(ctrl_q[`F_MODE +: 2]);

	// pick-up evaluation
	logic [W-1:0] mx, res;
	logic ph_over, rs_over, cur, st, run;
	always_comb
	begin
		mx = phase_current_a;
		if (phase_current_b > mx)
			mx = phase_current_b;
		if (phase_current_c > mx)
			mx = phase_current_c;
		unique case (ctrl_q[`F_RES_SEL +: 2])
			2'h0: res = residual_input_one;
			2'h1: res = residual_input_two;
			default: res = residual_calculated;
		endcase
		ph_over = mx > ph_thr_q;
		rs_over = res > res_thr_q;
		cur = ph_over | rs_over;
		unique case (mode)
			CRIT_CUR:
			begin
				st = cur;
				run = cur;
			end
			CRIT_AND:
			begin
				st = cur;
				run = cur & trip;
			end
			CRIT_OR:
			begin
				st = cur | trip;
				run = st;
			end
			CRIT_DI:
			begin
				st = di;
				run = di & (cur | ~ctrl_q[`F_CUR_SUP]) & (trip | ~ctrl_q[`F_DO_SUP]);
			end
		endcase
	end

	// timer state, outputs and events, advanced once per program cycle
	bf_state_t state_q, state_d;
	logic [W-1:0] cnt_q, cnt_d;
	logic cbf_q, cbf_d, ret_q, ret_d;
	ev_vec_t stat_q, stat_d, on_q, on_d, off_q, off_d, nv, rise;
	logic [31:0] stamp_q, stamp_d;
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		cbf_d = cbf_q;
		ret_d = ret_q;
		stat_d = stat_q;
		on_d = '0;
		off_d = '0;
		stamp_d = stamp_q;
		nv = stat_q;
		rise = '0;
		if (tick_q)
		begin
			unique case (state_q)
				ST_IDLE:
					if (st)
						state_d = blk ? ST_BLK : ST_RUN;
				ST_RUN:
					if (!st)
						state_d = ST_IDLE;
					else if (blk)
						state_d = ST_BLK;
				ST_BLK:
					if (!st)
						state_d = ST_IDLE;
			endcase
			if (state_d == ST_RUN && run)
				cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
			else
				cnt_d = '0;
			cbf_d = (state_d == ST_RUN) && run && (cnt_d >= cbf_dly_q);
			ret_d = (state_d == ST_RUN) && run && ctrl_q[`F_RET_EN] && (cnt_d >= ret_dly_q);
			nv[`EV_START] = state_d == ST_RUN;
			nv[`EV_RETRIP] = ret_d;
			nv[`EV_CBF] = cbf_d;
			nv[`EV_BLOCK] = state_d == ST_BLK;
			nv[`EV_DO] = trip;
			nv[`EV_SIGNAL] = di;
			nv[`EV_PHASE] = ph_over;
			nv[`EV_RES] = rs_over;
			rise = nv & ~stat_q;
			on_d = rise & mask_q[7:0];
			off_d = ~nv & stat_q & mask_q[15:8];
			stat_d = nv;
			stamp_d = time_q;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			cbf_q <= 1'b0;
			ret_q <= 1'b0;
			stat_q <= '0;
			on_q <= '0;
			off_q <= '0;
			stamp_q <= 32'h0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			cbf_q <= cbf_d;
			ret_q <= ret_d;
			stat_q <= stat_d;
			on_q <= on_d;
			off_q <= off_d;
			stamp_q <= stamp_d;
		end
	end
	assign breaker_failure_output = cbf_q;
	assign retrip_output = ret_q;
	assign start_output = stat_q[`EV_START];
	assign blocked_output = stat_q[`EV_BLOCK];
	assign breaker_failure_event_block_on = on_q;
	assign breaker_failure_event_block_off = off_q;
	assign event_stamp = stamp_q;

	// occurrence counters; a count arriving with its clear survives as one
	logic [`N_CNT*CW-1:0] cnt_flat;
	for (genvar gi = 0; gi < `N_CNT; gi++)
	begin : g_cnt
		logic [CW-1:0] c_q, c_d;
		always_comb
		begin
			c_d = c_q;
			if (rise[gi])
				c_d = clr_q[gi] ? CW'(1) : c_q + 1'b1;
			else if (clr_q[gi])
				c_d = '0;
		end
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				c_q <= '0;
			else
				c_q <= c_d;
		end
		assign cnt_flat[gi*CW +: CW] = c_q;
	end

	// record log, slot order; only the lowest numbered rising event is kept
	logic [31:0] lt_q [`LOG_DEPTH], lt_d [`LOG_DEPTH];
	logic [5:0] li_q [`LOG_DEPTH], li_d [`LOG_DEPTH];
	logic [2*W-1:0] lc_q [`LOG_DEPTH], lc_d [`LOG_DEPTH];
	logic [2*W-1:0] lr_q [`LOG_DEPTH], lr_d [`LOG_DEPTH];
	logic [3:0] ptr_q, ptr_d, fill_q, fill_d;
	logic [2:0] ev;
	logic [W-1:0] cbf_rem, ret_rem;
	always_comb
	begin
		lt_d = lt_q;
		li_d = li_q;
		lc_d = lc_q;
		lr_d = lr_q;
		ptr_d = ptr_q;
		fill_d = fill_q;
		ev = 3'h0;
		for (int i = `N_EV - 1; i >= 0; i--)
		begin
			if (rise[i])
				ev = 3'(i);
		end
		cbf_rem = (cnt_d >= cbf_dly_q) ? '0 : cbf_dly_q - cnt_d;
		ret_rem = (cnt_d >= ret_dly_q) ? '0 : ret_dly_q - cnt_d;
		if (|rise)
		begin
			lt_d[ptr_q] = time_q;
			li_d[ptr_q] = {ctrl_q[`F_GROUP +: 3], ev};
			lc_d[ptr_q] = {res, mx};
			lr_d[ptr_q] = {ret_rem, cbf_rem};
			ptr_d = (ptr_q == LD - 4'h1) ? 4'h0 : ptr_q + 4'h1;
			fill_d = (fill_q == LD) ? fill_q : fill_q + 4'h1;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ptr_q <= 4'h0;
			fill_q <= 4'h0;
			for (int i = 0; i < `LOG_DEPTH; i++)
			begin
				lt_q[i] <= 32'h0;
				li_q[i] <= 6'h0;
				lc_q[i] <= '0;
				lr_q[i] <= '0;
			end
		end
		else
		begin
			ptr_q <= ptr_d;
			fill_q <= fill_d;
			lt_q <= lt_d;
			li_q <= li_d;
			lc_q <= lc_d;
			lr_q <= lr_d;
		end
	end

	// axi4-lite slave; address and data may arrive in either order
	logic awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
	logic awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0] ws_q, ws_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	logic do_wr;
	always_comb
	begin
		awh_d = awh_q | (awvalid & awr_q);
		wh_d = wh_q | (wvalid & wr_q);
		awa_d = (awvalid & awr_q) ? awaddr : awa_q;
		wd_d = (wvalid & wr_q) ? wdata : wd_q;
		ws_d = (wvalid & wr_q) ? wstrb : ws_q;
		bv_d = bv_q & ~bready;
		br_d = br_q;
		ctrl_d = ctrl_q;
		cbf_dly_d = cbf_dly_q;
		ret_dly_d = ret_dly_q;
		ph_thr_d = ph_thr_q;
		res_thr_d = res_thr_q;
		mask_d = mask_q;
		sel_d = sel_q;
		clr_d = 4'h0;
		do_wr = awh_q & wh_q & ~bv_q;
		if (do_wr)
		begin
			awh_d = 1'b0;
			wh_d = 1'b0;
			bv_d = 1'b1;
			br_d = `RESP_OKAY;
			unique case (awa_q)
				`A_CTRL: ctrl_d = merge(ctrl_q, wd_q, ws_q) & `CTRL_MASK;
				`A_CBF_DLY: cbf_dly_d = W'(merge(32'(cbf_dly_q), wd_q, ws_q));
				`A_RET_DLY: ret_dly_d = W'(merge(32'(ret_dly_q), wd_q, ws_q));
				`A_PH_THR: ph_thr_d = W'(merge(32'(ph_thr_q), wd_q, ws_q));
				`A_RES_THR: res_thr_d = W'(merge(32'(res_thr_q), wd_q, ws_q));
				`A_EV_MASK: mask_d = 16'(merge(32'(mask_q), wd_q, ws_q));
				`A_LOG_SEL: sel_d = 4'(merge(32'(sel_q), wd_q, ws_q));
				`A_CNT_CLR: clr_d = ws_q[0] ? wd_q[3:0] : 4'h0;
				default: br_d = `RESP_SLVERR;
			endcase
		end
		awr_d = ~awh_d;
		wr_d = ~wh_d;
		rv_d = rv_q & ~rready;
		rd_d = rd_q;
		rr_d = rr_q;
		if (arvalid & arr_q)
		begin
			rv_d = 1'b1;
			rr_d = `RESP_OKAY;
			rd_d = 32'h0;
			unique case (araddr)
				`A_CTRL: rd_d = ctrl_q;
				`A_CBF_DLY: rd_d = 32'(cbf_dly_q);
				`A_RET_DLY: rd_d = 32'(ret_dly_q);
				`A_PH_THR: rd_d = 32'(ph_thr_q);
				`A_RES_THR: rd_d = 32'(res_thr_q);
				`A_EV_MASK: rd_d = 32'(mask_q);
				`A_LOG_SEL: rd_d = 32'(sel_q);
				`A_CNT_CLR: rd_d = 32'h0;
				`A_TIME: rd_d = time_q;
				`A_STATUS:
				begin
					rd_d[`F_ST_STATE +: 3] = state_q;
					rd_d[`F_ST_CBF] = cbf_q;
					rd_d[`F_ST_RET] = ret_q;
					rd_d[`F_ST_FILL +: 4] = fill_q;
					rd_d[`F_ST_EV +: `N_EV] = stat_q;
				end
				`A_LOG_TIME: rd_d = (sel_q < LD) ? lt_q[sel_q] : 32'h0;
				`A_LOG_INFO: rd_d = (sel_q < LD) ? 32'(li_q[sel_q]) : 32'h0;
				`A_LOG_CUR: rd_d = (sel_q < LD) ? 32'(lc_q[sel_q]) : 32'h0;
				`A_LOG_REM: rd_d = (sel_q < LD) ? 32'(lr_q[sel_q]) : 32'h0;
				default:
				begin
					rr_d = `RESP_SLVERR;
					for (int i = 0; i < `N_CNT; i++)
					begin
						if (araddr == `A_CNT0 + 8'(i) * `CNT_STRIDE)
						begin
							rd_d = 32'(cnt_flat[i*CW +: CW]);
							rr_d = `RESP_OKAY;
						end
					end
				end
			endcase
		end
		arr_d = ~rv_d;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awr_q <= 1'b0;
			wr_q <= 1'b0;
			arr_q <= 1'b0;
			awh_q <= 1'b0;
			wh_q <= 1'b0;
			bv_q <= 1'b0;
			rv_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			rd_q <= 32'h0;
			br_q <= `RESP_OKAY;
			rr_q <= `RESP_OKAY;
			ctrl_q <= `CTRL_RST;
			cbf_dly_q <= W'(`CBF_DELAY_MS / `DELAY_STEP_MS);
			ret_dly_q <= W'(`RETRIP_DELAY_MS / `DELAY_STEP_MS);
			ph_thr_q <= W'(`THR_RST);
			res_thr_q <= W'(`THR_RST);
			mask_q <= `EV_MASK_RST;
			sel_q <= 4'h0;
			clr_q <= 4'h0;
		end
		else
		begin
			awr_q <= awr_d;
			wr_q <= wr_d;
			arr_q <= arr_d;
			awh_q <= awh_d;
			wh_q <= wh_d;
			bv_q <= bv_d;
			rv_q <= rv_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			rd_q <= rd_d;
			br_q <= br_d;
			rr_q <= rr_d;
			ctrl_q <= ctrl_d;
			cbf_dly_q <= cbf_dly_d;
			ret_dly_q <= ret_dly_d;
			ph_thr_q <= ph_thr_d;
			res_thr_q <= res_thr_d;
			mask_q <= mask_d;
			sel_q <= sel_d;
			clr_q <= clr_d;
		end
	end
	assign awready = awr_q;
	assign wready = wr_q;
	assign bvalid = bv_q;
	assign bresp = br_q;
	assign arready = arr_q;
	assign rvalid = rv_q;
	assign rdata = rd_q;
	assign rresp = rr_q;
endmodule // breaker_failure_timer_logic

/* File: tb/primary_protection_model.sv */
// primary protection stage model: trip contact closes after its own operate time
module primary_protection_model (
	input wire logic aclk,
	input wire logic fault,
	input wire logic slow,
	output logic trip_monitor_pin = 1'h0,
	output logic start_input_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	// slow stage lets the supervised counter see a late trip
	always @(posedge aclk)
	begin
		n <= fault ? n + 1 : 0;
		trip_monitor_pin <= fault && n >= (slow ? 30 : 2);
	end
	assign start_input_pin = trip_monitor_pin;
endmodule // primary_protection_model

/* File: tb/breaker_failure_props.sv */
// port checker for the breaker failure timer
module breaker_failure_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic breaker_failure_output,
	input wire logic start_output,
	input wire logic blocked_output,
	input wire breaker_failure_pkg::ev_vec_t breaker_failure_event_block_on,
	input wire breaker_failure_pkg::ev_vec_t breaker_failure_event_block_off
);
	import breaker_failure_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_b_wait;
		bvalid && !bready;
	endsequence
	sequence s_fail_rise;
		$rose(breaker_failure_output);
	endsequence
	property p_b_hold;
		s_b_wait |=> bvalid;
	endproperty
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	property p_run_blk;
		!(start_output && blocked_output);
	endproperty
	property p_fail_run;
		breaker_failure_output |-> start_output;
	endproperty
	property p_on_off;
		(breaker_failure_event_block_on & breaker_failure_event_block_off) == '0;
	endproperty
	property p_pulse;
		|breaker_failure_event_block_on |=> breaker_failure_event_block_on == '0;
	endproperty
	property p_fail_on;
		breaker_failure_event_block_on[2] |-> s_fail_rise;
	endproperty
	property p_fail_off;
		breaker_failure_event_block_off[2] |-> $fell(breaker_failure_output);
	endproperty
	property p_start_on;
		breaker_failure_event_block_on[0] |-> $rose(start_output);
	endproperty
	property p_fail_hold;
		s_fail_rise |=> breaker_failure_output [*8];
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	a_run_blk: assert property (p_run_blk) else $error("run and blocked together");
	a_fail_run: assert property (p_fail_run) else $error("failure without run");
	a_on_off: assert property (p_on_off) else $error("on and off in one pulse");
	a_pulse: assert property (p_pulse) else $error("event pulse too long");
	a_fail_on: assert property (p_fail_on) else $error("failure on event mistimed");
	a_fail_off: assert property (p_fail_off) else $error("failure off event mistimed");
	a_start_on: assert property (p_start_on) else $error("start on event mistimed");
	a_fail_hold: assert property (p_fail_hold) else $error("failure output glitch");
endmodule // breaker_failure_props
bind breaker_failure_timer_logic breaker_failure_props u_breaker_failure_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.bvalid(bvalid),
	.bready(bready),
	.rvalid(rvalid),
	.rready(rready),
	.rdata(rdata),
	.breaker_failure_output(breaker_failure_output),
	.start_output(start_output),
	.blocked_output(blocked_output),
	.breaker_failure_event_block_on(breaker_failure_event_block_on),
	.breaker_failure_event_block_off(breaker_failure_event_block_off)
);

/* File: tb/breaker_failure_timer_logic_bench.sv */
// self-checking bench of the breaker failure timer
module breaker_failure_timer_logic_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PC = 20;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fault, slow, block_pin;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic [15:0] ph_a, ph_b, ph_c, res1, res2, resc;
	wire logic awready, wready, bvalid, arready, rvalid, bfo, start_o, blk_o, trip_pin, si_pin;
	wire logic ret_o;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire breaker_failure_pkg::ev_vec_t ev_on, ev_off;
	int miscompares = 0;
	int checks_done = 0;
	int cyc = 0;
	breaker_failure_timer_logic #(.PROG_CYCLES(PC), .MS_CYCLES(4)) u_breaker_failure_timer_logic (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.phase_current_a(ph_a), .phase_current_b(ph_b), .phase_current_c(ph_c),
		.residual_input_one(res1), .residual_input_two(res2), .residual_calculated(resc),
		.trip_monitor_pin(trip_pin), .start_input_pin(si_pin), .block_pin(block_pin),
		.breaker_failure_output(bfo), .retrip_output(ret_o), .start_output(start_o),
		.blocked_output(blk_o), .breaker_failure_event_block_on(ev_on),
		.breaker_failure_event_block_off(ev_off), .event_stamp()
	);
	primary_protection_model u_primary_protection_model (
		.aclk(aclk), .fault(fault), .slow(slow),
		.trip_monitor_pin(trip_pin), .start_input_pin(si_pin)
	);
	task wrap_up;
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ta, tw;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		ta = 0;
		tw = 0;
		while (!(ta && tw))
		begin
			@(posedge aclk);
			if (awready && !ta)
			begin
				ta = 1;
				awvalid <= 1'h0;
			end
			if (wready && !tw)
			begin
				tw = 1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'h1);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		t = 0;
		do
		begin
			@(posedge aclk);
			if (arready && !t)
			begin
				t = 1;
				arvalid <= 1'h0;
			end
		end while (!(t && rvalid === 1'h1));
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return bfo;
			1: return start_o;
			default: return blk_o;
		endcase
	endfunction
	task automatic wt(input int s, input logic v, output int n);
		n = 0;
		while (sig(s) !== v && n < 200)
		begin
			@(posedge aclk);
			n++;
		end
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rd(8'h04, d, r);
		chk(d, 32'h28);
		rd(8'h14, d, r);
		chk(d, 32'hFFFF);
		rd(8'h80, d, r);
		chk(r, 2'h2);
	endtask
	task automatic t_cur;
		int n;
		wr(8'h04, 32'h3);
		wr(8'h08, 32'h2);
		wr(8'h00, 32'h4);
		ph_b <= 16'h0101;
		wt(1, 1'h1, n);
		wt(0, 1'h1, n);
		chk(n, 2 * PC);
		// retrip at two steps, one tick ahead of the failure output
		chk(ret_o, 1'h1);
		ph_b <= 16'h0100;
		wt(0, 1'h0, n);
		chk({ret_o, start_o, bfo}, 3'h0);
		res1 <= 16'h0101;
		wt(1, 1'h1, n);
		chk(start_o, 1'h1);
		res1 <= 16'h0;
		wt(1, 1'h0, n);
	endtask
	task automatic t_and;
		int n;
		wr(8'h00, 32'h1);
		ph_a <= 16'h0200;
		wt(1, 1'h1, n);
		repeat (5 * PC) @(posedge aclk);
		chk(bfo, 1'h0);
		fault <= 1'h1;
		wt(0, 1'h1, n);
		chk(n <= 4 * PC, 1'h1);
		fault <= 1'h0;
		wt(0, 1'h0, n);
		chk(n <= PC + 6, 1'h1);
		ph_a <= 16'h0;
		wt(1, 1'h0, n);
	endtask
	task automatic t_or;
		int n;
		wr(8'h00, 32'h2);
		fault <= 1'h1;
		wt(0, 1'h1, n);
		chk(bfo, 1'h1);
		ph_b <= 16'h0101;
		fault <= 1'h0;
		repeat (3 * PC) @(posedge aclk);
		chk(bfo, 1'h1);
		ph_b <= 16'h0;
		wt(0, 1'h0, n);
		chk(n <= PC + 2, 1'h1);
	endtask
	task automatic t_di;
		int n;
		wr(8'h00, 32'h3);
		ph_b <= 16'h0101;
		repeat (3 * PC) @(posedge aclk);
		chk(start_o, 1'h0);
		ph_b <= 16'h0;
		slow <= 1'h1;
		fault <= 1'h1;
		wt(1, 1'h1, n);
		wt(0, 1'h1, n);
		chk(n, 2 * PC);
		fault <= 1'h0;
		slow <= 1'h0;
		wt(1, 1'h0, n);
	endtask
	task automatic t_blk;
		int n;
		wr(8'h00, 32'h0);
		// block on event masked out, its off event kept
		wr(8'h14, 32'hFFF7);
		block_pin <= 1'h1;
		repeat (4) @(posedge aclk);
		ph_b <= 16'h0101;
		wt(2, 1'h1, n);
		chk(blk_o, 1'h1);
		chk(ev_on, 32'h40);
		block_pin <= 1'h0;
		repeat (4 * PC) @(posedge aclk);
		chk({blk_o, bfo}, 2'h2);
		ph_b <= 16'h0;
		wt(2, 1'h0, n);
		chk(blk_o, 1'h0);
		chk(ev_off, 32'h48);
	endtask
	task automatic t_cnt;
		logic [31:0] d;
		logic [1:0] r;
		logic [31:0] exp [4] = '{32'h5, 32'h1, 32'h4, 32'h1};
		for (int i = 0; i < 4; i++)
		begin
			rd(8'h20 + 8'(4 * i), d, r);
			chk(d, exp[i]);
		end
		rd(8'h18, d, r);
		chk(d[11:8], 4'hC);
		// fourteen records so far: slot 1 holds the blocked pick-up
		wr(8'h30, 32'h1);
		rd(8'h38, d, r);
		chk(d, 32'h3);
		rd(8'h3C, d, r);
		chk(d, 32'h0000_0101);
		wr(8'h1C, 32'hF);
		rd(8'h28, d, r);
		chk(d, 32'h0);
	endtask
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			wrap_up;
		end
	end
	initial
	begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, fault, slow, block_pin} = '0;
		{awaddr, araddr, wdata} = '0;
		{ph_a, ph_b, ph_c, res1, res2, resc} = '0;
		wstrb = 4'hF;
		aresetn = 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		t_regs;
		t_cur;
		t_and;
		t_or;
		t_di;
		t_blk;
		t_cnt;
		wrap_up;
	end
endmodule // breaker_failure_timer_logic_bench
